// ==== src/ipf_regs.vh ====
/*
 Register offsets, field layout and reset values of the indirect pointer file.
 Assumes an 8-bit register port with byte-wide offsets chosen for this block.
*/
`ifndef IPF_REGS_VH
`define IPF_REGS_VH

`define IPF_ADDR_W        8
`define IPF_DM_AW         12
`define IPF_OFF_WACC      8'h00
`define IPF_OFF_P1_PLAIN  8'h01
`define IPF_OFF_P1_POSTI  8'h02
`define IPF_OFF_P1_POSTD  8'h03
`define IPF_OFF_P1_PREI   8'h04
`define IPF_OFF_P1_OFFS   8'h05
`define IPF_OFF_P1_HIGH   8'h06
`define IPF_OFF_P1_LOW    8'h07
`define IPF_OFF_BANK      8'h08
`define IPF_OFF_P2_PLAIN  8'h09
`define IPF_OFF_P2_POSTI  8'h0A
`define IPF_OFF_P2_POSTD  8'h0B
`define IPF_OFF_P2_PREI   8'h0C
`define IPF_OFF_P2_OFFS   8'h0D
`define IPF_OFF_P2_HIGH   8'h0E
`define IPF_OFF_P2_LOW    8'h0F
`define IPF_OFF_FLAGS     8'h10
`define IPF_HIGH_W        4
`define IPF_FLAGS_W       5
`define IPF_RST_HIGH      4'h0
`define IPF_RST_BANK      4'h0
`define IPF_RST_LOW       8'h00
`define IPF_RST_WACC      8'h00
`define IPF_RST_FLAGS     5'h00

`endif

// ==== src/ipf_pointer_file.v ====
/*
 Indirect data-memory pointer file: two 12-bit pointers, their virtual operand
 locations, the working accumulator, the bank selector and the arithmetic flags.
 Assumes data memory answers combinationally on dm_rdata for dm_addr, and a
 register port master with one-cycle strobes, never both at once.
*/
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "ipf_regs.vh"
// How it works
// [RL1] Indirect locations access data memory at the pointer's address, not own storage.
// [RL2] Post-decrement addresses with current pointer, then lowers pointer by one.
// [RL3] Offset location addresses pointer plus accumulator; pointer stays unchanged.
// [RL4] Indirect locations are pure address decodes with no state or reset.
// [RL5] Pointer high byte holds only four bits, cleared at reset; upper bits absent.
// [RL6] Software leaves compatibility-reserved bits unchanged.
// [RL7] On small variants software keeps variant-reserved bits at zero.
// [RL8] Plain keeps pointer; post-increment adds one after; pre-increment adds one before.
module ipf_pointer_file (
  // Clock and reset
  input  wire                    clk,
  input  wire                    srst,
  // Register port
  input  wire [`IPF_ADDR_W-1:0]  reg_addr,
  input  wire [7:0]              reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [7:0]              reg_rdata,
  // Data memory
  output reg  [`IPF_DM_AW-1:0]   dm_addr,
  output reg  [7:0]              dm_wdata,
  output reg                     dm_we,
  input  wire [7:0]              dm_rdata,
  // Flag updates from the arithmetic unit
  input  wire                    flags_upd,
  input  wire [`IPF_FLAGS_W-1:0] flags_in,
  // Pointer and bank state
  output wire [`IPF_DM_AW-1:0]   ptr1_addr,
  output wire [`IPF_DM_AW-1:0]   ptr2_addr,
  output wire [3:0]              bank_sel
);

  localparam [2:0] M_NONE  = 3'h0;
  localparam [2:0] M_PLAIN = 3'h1;
  localparam [2:0] M_POSTI = 3'h2;
  localparam [2:0] M_POSTD = 3'h3;
  localparam [2:0] M_PREI  = 3'h4;
  localparam [2:0] M_OFFS  = 3'h5;

  reg  [7:0]              wacc_q;
  reg  [`IPF_HIGH_W-1:0]  p1_high_q;
  reg  [7:0]              p1_low_q;
  reg  [`IPF_HIGH_W-1:0]  p2_high_q;
  reg  [7:0]              p2_low_q;
  reg  [3:0]              bank_q;
  reg  [`IPF_FLAGS_W-1:0] flags_q;
  reg  [2:0]              mode;
  reg                     sel2;
  reg  [`IPF_DM_AW-1:0]   ptr;
  reg  [`IPF_DM_AW-1:0]   ptr_d;
  reg  [7:0]              rdata_d;

  // Access decode
  reg                     acc_ind;
  reg                     upd1;
  reg                     upd2;
  reg                     wr_wacc;
  reg                     wr_p1_high;
  reg                     wr_p1_low;
  reg                     wr_p2_high;
  reg                     wr_p2_low;
  reg                     wr_bank;
  reg                     wr_flags;

  assign ptr1_addr = {p1_high_q, p1_low_q};
  assign ptr2_addr = {p2_high_q, p2_low_q};
  assign bank_sel  = bank_q;

  // Map an offset to its indirect access mode
  function [2:0] ind_mode;
    input [`IPF_ADDR_W-1:0] a;
    begin
      case (a)
        `IPF_OFF_P1_PLAIN, `IPF_OFF_P2_PLAIN: ind_mode = M_PLAIN;
        `IPF_OFF_P1_POSTI, `IPF_OFF_P2_POSTI: ind_mode = M_POSTI;
        `IPF_OFF_P1_POSTD, `IPF_OFF_P2_POSTD: ind_mode = M_POSTD;
        `IPF_OFF_P1_PREI,  `IPF_OFF_P2_PREI:  ind_mode = M_PREI;
        `IPF_OFF_P1_OFFS,  `IPF_OFF_P2_OFFS:  ind_mode = M_OFFS;
        default:                              ind_mode = M_NONE;
      endcase
    end
  endfunction

  // Pointer plus one, wrapping at the top of data memory
  function [`IPF_DM_AW-1:0] ptr_inc;
    input [`IPF_DM_AW-1:0] v;
    begin
      ptr_inc = v + 12'h001;
    end
  endfunction

  // Pointer minus one, wrapping below zero
  function [`IPF_DM_AW-1:0] ptr_dec;
    input [`IPF_DM_AW-1:0] v;
    begin
      ptr_dec = v - 12'h001;
    end
  endfunction

  // Four-bit field read back with absent upper bits as zero
  function [7:0] ext4;
    input [3:0] v;
    begin
      ext4 = {4'h0, v};
    end
  endfunction

  // Write strobe aimed at one register offset
  function wr_hit;
    input                   wr;
    input [`IPF_ADDR_W-1:0] a;
    input [`IPF_ADDR_W-1:0] off;
    begin
      wr_hit = wr && (a == off);
    end
  endfunction

  // Address forming and pointer update for indirect accesses
  always @*
  begin
    mode     = (reg_wr || reg_rd) ? ind_mode(reg_addr) : M_NONE; // [RL4]
    sel2     = (reg_addr >= `IPF_OFF_P2_PLAIN);
    ptr      = sel2 ? ptr2_addr : ptr1_addr;
    ptr_d    = ptr;
    dm_addr  = ptr;                                              // [RL1]
    dm_wdata = reg_wdata;
    dm_we    = reg_wr && (mode != M_NONE);                       // [RL1]
    case (mode)
      M_PLAIN:
        ptr_d = ptr;                                             // [RL8]
      M_POSTI:
        ptr_d = ptr_inc(ptr);                                    // [RL8]
      M_POSTD:
        ptr_d = ptr_dec(ptr);                                    // [RL2]
      M_PREI:
      begin
        ptr_d   = ptr_inc(ptr);                                  // [RL8]
        dm_addr = ptr_d;
      end
      M_OFFS:
        dm_addr = ptr + {4'h0, wacc_q};                          // [RL3]
      default:
        ptr_d = ptr;
    endcase
  end

  // Read mux
  always @*
  begin
    case (reg_addr)
      `IPF_OFF_WACC:    rdata_d = wacc_q;
      `IPF_OFF_P1_HIGH: rdata_d = ext4(p1_high_q);               // [RL5]
      `IPF_OFF_P1_LOW:  rdata_d = p1_low_q;
      `IPF_OFF_BANK:    rdata_d = ext4(bank_q);
      `IPF_OFF_P2_HIGH: rdata_d = ext4(p2_high_q);               // [RL5]
      `IPF_OFF_P2_LOW:  rdata_d = p2_low_q;
      `IPF_OFF_FLAGS:   rdata_d = {3'h0, flags_q};
      default:          rdata_d = (mode != M_NONE) ? dm_rdata : 8'h00; // [RL1]
    endcase
  end

  // Which register a strobe touches
  always @*
  begin
    acc_ind    = (mode != M_NONE);                               // [RL4]
    upd1       = acc_ind && !sel2;
    upd2       = acc_ind && sel2;
    wr_wacc    = wr_hit(reg_wr, reg_addr, `IPF_OFF_WACC);
    wr_p1_high = wr_hit(reg_wr, reg_addr, `IPF_OFF_P1_HIGH);
    wr_p1_low  = wr_hit(reg_wr, reg_addr, `IPF_OFF_P1_LOW);
    wr_p2_high = wr_hit(reg_wr, reg_addr, `IPF_OFF_P2_HIGH);
    wr_p2_low  = wr_hit(reg_wr, reg_addr, `IPF_OFF_P2_LOW);
    wr_bank    = wr_hit(reg_wr, reg_addr, `IPF_OFF_BANK);
    wr_flags   = wr_hit(reg_wr, reg_addr, `IPF_OFF_FLAGS);
  end

  // Working accumulator
  always @(posedge clk)
  begin
    if (srst)
    begin
      wacc_q <= `IPF_RST_WACC;
    end
    else if (wr_wacc)
    begin
      wacc_q <= reg_wdata;
    end
  end

  // Pointer 1 high byte; a direct byte write wins over an update
  always @(posedge clk)
  begin
    if (srst)
    begin
      p1_high_q <= `IPF_RST_HIGH;                                // [RL5]
    end
    else if (wr_p1_high)
    begin
      p1_high_q <= reg_wdata[`IPF_HIGH_W-1:0];                   // [RL5]
    end
    else if (upd1)
    begin
      p1_high_q <= ptr_d[`IPF_DM_AW-1:8];                        // [RL2] [RL8]
    end
  end

  // Pointer 1 low byte
  always @(posedge clk)
  begin
    if (srst)
    begin
      p1_low_q <= `IPF_RST_LOW;
    end
    else if (wr_p1_low)
    begin
      p1_low_q <= reg_wdata;
    end
    else if (upd1)
    begin
      p1_low_q <= ptr_d[7:0];                                    // [RL2] [RL8]
    end
  end

  // Pointer 2 high byte; a direct byte write wins over an update
  always @(posedge clk)
  begin
    if (srst)
    begin
      p2_high_q <= `IPF_RST_HIGH;                                // [RL5]
    end
    else if (wr_p2_high)
    begin
      p2_high_q <= reg_wdata[`IPF_HIGH_W-1:0];                   // [RL5]
    end
    else if (upd2)
    begin
      p2_high_q <= ptr_d[`IPF_DM_AW-1:8];                        // [RL2] [RL8]
    end
  end

  // Pointer 2 low byte
  always @(posedge clk)
  begin
    if (srst)
    begin
      p2_low_q <= `IPF_RST_LOW;
    end
    else if (wr_p2_low)
    begin
      p2_low_q <= reg_wdata;
    end
    else if (upd2)
    begin
      p2_low_q <= ptr_d[7:0];                                    // [RL2] [RL8]
    end
  end

  // Bank selector, four bits
  always @(posedge clk)
  begin
    if (srst)
    begin
      bank_q <= `IPF_RST_BANK;
    end
    else if (wr_bank)
    begin
      bank_q <= reg_wdata[3:0];
    end
  end

  // Flags; software write takes precedence over arithmetic update
  always @(posedge clk)
  begin
    if (srst)
    begin
      flags_q <= `IPF_RST_FLAGS;
    end
    else if (wr_flags)
    begin
      flags_q <= reg_wdata[`IPF_FLAGS_W-1:0];
    end
    else if (flags_upd)
    begin
      flags_q <= flags_in;
    end
  end

  // Read data stands one cycle after the strobe, else zero
  always @(posedge clk)
  begin
    if (srst)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_rdata <= reg_rd ? rdata_d : 8'h00;                     // [RL1]
    end
  end

endmodule // ipf_pointer_file

// ==== test/ipf_checker.sv ====
/* Port checker for the pointer file.
 Assumes it is bound to the pointer file top. */
`timescale 1ns/1ps
module ipf_checker (
  // Clock and reset
  input wire        clk,
  input wire        srst,
  // Register port
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  // Data memory and pointers
  input wire [11:0] dm_addr,
  input wire        dm_we,
  input wire [7:0]  dm_rdata,
  input wire [11:0] ptr1_addr,
  input wire [11:0] ptr2_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire s = reg_wr | reg_rd;
  property p_plain; s && reg_addr == 8'h01 |-> dm_addr == ptr1_addr ##1 ptr1_addr == $past(ptr1_addr); endproperty
  a_plain: assert property (p_plain) else $error("plain access moved pointer");
  property p_pdec; s && reg_addr == 8'h03 |-> dm_addr == ptr1_addr ##1 ptr1_addr == $past(ptr1_addr) - 12'h1;
  endproperty
  a_pdec: assert property (p_pdec) else $error("post-decrement wrong");
  property p_pinc; s && reg_addr == 8'h04 |-> dm_addr == ptr1_addr + 12'h1 ##1 ptr1_addr == $past(dm_addr);
  endproperty
  a_pinc: assert property (p_pinc) else $error("pre-increment wrong");
  property p_poinc; s && reg_addr == 8'h0A |-> dm_addr == ptr2_addr ##1 ptr2_addr == $past(ptr2_addr) + 12'h1;
  endproperty
  a_poinc: assert property (p_poinc) else $error("post-increment wrong");
  property p_offs; s && reg_addr == 8'h0D |=> $stable(ptr2_addr); endproperty
  a_offs: assert property (p_offs) else $error("offset access moved pointer");
  property p_we; dm_we |-> reg_wr && reg_addr[7:4] == 4'h0 && reg_addr[2:0] inside {[3'h1:3'h5]}; endproperty
  a_we: assert property (p_we) else $error("memory write outside indirect decode");
  property p_rdm; reg_rd && reg_addr == 8'h09 |=> reg_rdata == $past(dm_rdata); endproperty
  a_rdm: assert property (p_rdm) else $error("indirect read not from memory");
  property p_rst; $past(srst) |-> ptr1_addr == 12'h0 && ptr2_addr == 12'h0; endproperty
  a_rst: assert property (p_rst) else $error("pointers not cleared");
endmodule // ipf_checker

// ==== test/ipf_pointer_file_tb.sv ====
/* Random register traffic against a pointer and memory model.
 Assumes read data one cycle after the strobe. */
`timescale 1ns/1ps
module ipf_pointer_file_tb;
  reg         clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, flags_upd = 0;
  reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, mem [0:4095];
  reg  [4:0]  flags_in = 5'h00;
  wire [7:0]  reg_rdata, dm_wdata, dm_rdata;
  wire [11:0] dm_addr, ptr1_addr, ptr2_addr;
  wire [3:0]  bank_sel;
  wire        dm_we;
  reg  [7:0]  rst_off [0:6] = '{8'h00, 8'h06, 8'h07, 8'h08, 8'h0E, 8'h0F, 8'h10};
  int         num_errors = 0, compares = 0, ref_m [0:4095], p [1:2], w = 0, k, n, d, a, q, wr;
  always #4 clk = ~clk;
  assign dm_rdata = mem[dm_addr];
  always @(posedge clk) if (dm_we) mem[dm_addr] <= dm_wdata;
  ipf_pointer_file dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we),
    .dm_rdata(dm_rdata), .flags_upd(flags_upd), .flags_in(flags_in), .ptr1_addr(ptr1_addr),
    .ptr2_addr(ptr2_addr), .bank_sel(bank_sel));
  task chk(input logic [11:0] s, input logic [11:0] e);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task op(input bit we, input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= we;
    reg_rd <= !we;
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 0;
    #1;
  endtask
  task test_done;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    void'($urandom(25));
    p = '{0, 0};
    for (int j = 0; j < 4096; j++)
    begin
      mem[j] = $urandom;
      ref_m[j] = mem[j];
    end
    repeat (10) @(posedge clk);
    srst <= 0;
    for (int r = 0; r < 7; r++)
    begin
      op(0, rst_off[r], 0);
      chk(reg_rdata, 0);
    end
    op(1, 8'h08, 8'hFF);
    op(0, 8'h08, 0);
    chk(reg_rdata, 12'h00F);
    chk(bank_sel, 4'hF);
    @(posedge clk);
    flags_upd <= 1;
    flags_in <= 5'h15;
    @(posedge clk);
    flags_upd <= 0;
    op(0, 8'h10, 0);
    chk(reg_rdata, 12'h015);
    @(posedge clk);
    reg_addr <= 8'h10;
    reg_wdata <= 8'h0A;
    reg_wr <= 1;
    flags_upd <= 1;
    flags_in <= 5'h1F;
    @(posedge clk);
    reg_wr <= 0;
    flags_upd <= 0;
    op(0, 8'h10, 0);
    chk(reg_rdata, 12'h00A);
    for (int i = 0; i < 600; i++)
    begin
      k = $urandom % 10;
      n = 1 + $urandom % 2;
      d = $urandom % 256;
      wr = $urandom % 2;
      a = n == 1 ? 1 : 9;
      q = p[n];
      if (k < 5)
      begin
        if (k == 1) p[n] = q + 1;
        if (k == 2) p[n] = q - 1;
        if (k == 3) p[n] = ++q;
        if (k == 4) q += w;
        q &= 12'hFFF;
        p[n] &= 12'hFFF;
        op(wr, 8'(a + k), 8'(d));
        if (wr) ref_m[q] = d;
        else chk(reg_rdata, ref_m[q]);
      end
      else if (k == 5) begin op(1, 8'(a + 5), 8'(d)); p[n] = (q & 255) | ((d & 15) << 8); end
      else if (k == 6) begin op(1, 8'(a + 6), 8'(d)); p[n] = (q & 12'hF00) | d; end
      else if (k == 7)
      begin
        op(1, 8'h00, 8'(d));
        w = d;
        op(0, 8'h00, 0);
        chk(reg_rdata, w);
      end
      else if (k == 8)
      begin
        op(0, 8'(a + 5), 0);
        chk(reg_rdata, q >> 8);
        op(0, 8'(a + 6), 0);
        chk(reg_rdata, q & 255);
      end
      else begin op(1, 8'(17 + d % 200), 8'(d)); op(0, 8'(17 + d % 200), 0); chk(reg_rdata, 0); end
      chk(ptr1_addr, p[1]);
      chk(ptr2_addr, p[2]);
    end
    for (int j = 0; j < 4096; j++) chk(mem[j], ref_m[j]);
    @(posedge clk) srst <= 1;
    @(posedge clk) srst <= 0;
    #1 chk(ptr1_addr | ptr2_addr, 0);
    test_done;
  end
endmodule // ipf_pointer_file_tb
bind ipf_pointer_file ipf_checker u_chk (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dm_addr(dm_addr), .dm_we(dm_we), .dm_rdata(dm_rdata),
  .ptr1_addr(ptr1_addr), .ptr2_addr(ptr2_addr));
